// *** rtl/lcd_bus_pkg.sv ***
// shared constants and carriers for the lcd parallel bus master
package lcd_bus_pkg;

  // ************************************************************
  // register map (byte addresses)
  // ************************************************************
  localparam int unsigned ADDR_W = 5;
  localparam logic [4:0] OFS_QUEUE   = 5'h00; // push command/data byte
  localparam logic [4:0] OFS_FLAGS   = 5'h04; // interface_flags
  localparam logic [4:0] OFS_RD_LOW  = 5'h08; // read_data_low
  localparam logic [4:0] OFS_RD_HIGH = 5'h0c; // read_data_high
  localparam logic [4:0] OFS_LOW_W   = 5'h10; // read strobe low width
  localparam logic [4:0] OFS_HIGH_W  = 5'h14; // read strobe high width
  localparam logic [4:0] OFS_CTRL    = 5'h18; // bus width select

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int unsigned FLG_ROOM  = 0; // queue_room_flag
  localparam int unsigned FLG_VALID = 1; // read data valid
  localparam int unsigned FLG_BUSY  = 2; // transaction in progress
  localparam int unsigned CMD_READ  = 0; // command byte: 1 = read
  localparam int unsigned CMD_DC    = 1; // command byte: d/c value
  localparam int unsigned CTRL_WIDE = 0; // 1 = 16-bit bus

  // ************************************************************
  // reset values and limits
  // ************************************************************
  localparam logic [7:0] LOW_W_RST  = 8'h02;
  localparam logic [7:0] HIGH_W_RST = 8'h01;
  localparam logic [7:0] LOW_W_MIN  = 8'h02;
  localparam logic [7:0] HIGH_W_MIN = 8'h01;
  localparam logic [7:0] CTRL_RST   = 8'h00;
  localparam int unsigned ROOM_MIN  = 2;    // bytes of room for flag
  localparam int unsigned QUEUE_DEPTH = 8;  // two 3-byte writes + slack

  // ************************************************************
  // carriers
  // ************************************************************
  typedef struct packed {
    logic             wr;    // write strobe
    logic             rd;    // read strobe
    logic [4:0]       addr;  // byte address
    logic [7:0]       wdata; // write data
  } reg_req_t;

  typedef struct packed {
    logic        dc;       // 1 data, 0 command
    logic        cs_n;     // chip select, active low
    logic        wr_n;     // write strobe, active low
    logic        rd_n;     // read strobe, active low
    logic        oe;       // output bus enable
    logic [15:0] out_bus;  // write data, high byte on [15:8]
  } lcd_pins_t;

endpackage : lcd_bus_pkg

// *** rtl/cmd_queue.sv ***
// byte queue shared by command and write data bytes
`timescale 1ns/1ps
module cmd_queue #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  // clock and reset
  input  wire logic                     ref_clk,
  input  wire logic                     sys_rst,
  // fill side
  input  wire logic                     push,
  input  wire logic [WIDTH-1:0]         push_data,
  // drain side, data registered one cycle after pop
  input  wire logic                     pop,
  output logic      [WIDTH-1:0]         pop_data_q,
  // state
  output logic                          empty,
  output logic                          full,
  output logic      [$clog2(DEPTH):0]   free
);
  localparam int unsigned PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];   // storage
  logic [PW-1:0]    wptr_q;          // write pointer
  logic [PW-1:0]    rptr_q;          // read pointer
  logic [PW:0]      cnt_q;           // bytes held

  // refused moves are filtered here, so callers may strobe blindly
  wire do_push = push & ~full;
  wire do_pop  = pop & ~empty;

  assign empty = (cnt_q == '0);
  assign full  = (cnt_q == (PW+1)'(DEPTH));
  assign free  = (PW+1)'(DEPTH) - cnt_q;

  // storage write and registered read
  always_ff @(posedge ref_clk) begin
    if (do_push) begin
      mem_q[wptr_q] <= push_data;
    end
    if (do_pop) begin
      pop_data_q <= mem_q[rptr_q];
    end
  end

  // pointers and occupancy
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      wptr_q <= '0;
      rptr_q <= '0;
      cnt_q  <= '0;
    end else begin
      wptr_q <= wptr_q + PW'(do_push);
      rptr_q <= rptr_q + PW'(do_pop);
      cnt_q  <= cnt_q + (PW+1)'(do_push) - (PW+1)'(do_pop);
    end
  end
endmodule : cmd_queue

// *** rtl/strobe_timer.sv ***
// down counter that times the read strobe low and high phases
`timescale 1ns/1ps
module strobe_timer #(
  parameter int unsigned W = 8
) (
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         sys_rst,
  // control
  input  wire logic         load,
  input  wire logic [W-1:0] value,
  // state
  output logic      [W-1:0] left_q
);
  // load wins over counting; holds at zero when spent
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      left_q <= '0;
    end else if (load) begin
      left_q <= value;
    end else if (left_q != '0) begin
      left_q <= left_q - W'(1);
    end
  end
endmodule : strobe_timer

// *** rtl/lcd_parallel_bus_master.sv ***
// parallel bus master toward an external graphic lcd controller
//
// Design decisions made here: the register addresses and the strobed register port.
`timescale 1ns/1ps

module lcd_parallel_bus_master #(
  parameter int unsigned DEPTH = lcd_bus_pkg::QUEUE_DEPTH
) (
  // clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  sys_rst,
  // register port
  input  wire lcd_bus_pkg::reg_req_t req,
  output logic [7:0]                 rdata_q,
  // panel pins
  output lcd_bus_pkg::lcd_pins_t     pins_q,
  input  wire logic [15:0]           in_bus
);
  import lcd_bus_pkg::*;

  // ************************************************************
  // engine states
  // ************************************************************
  typedef enum logic [8:0] {
    S_IDLE    = 9'b000000001, // waiting for a command byte
    S_CMD     = 9'b000000010, // command byte on queue output
    S_DATA_LO = 9'b000000100, // low byte on queue output
    S_DATA_HI = 9'b000001000, // high byte on queue output
    S_W_SETUP = 9'b000010000, // select low, data driven
    S_W_STB   = 9'b000100000, // write strobe low
    S_W_HOLD  = 9'b001000000, // strobe back high, data held
    S_R_LOW   = 9'b010000000, // read strobe low phase
    S_R_HIGH  = 9'b100000000  // read strobe high phase
  } state_t;

  state_t state_q;   // current state
  state_t state_d;   // next state

  // ************************************************************
  // configuration and result registers
  // ************************************************************
  logic [7:0] low_w_q;        // read strobe low width setting
  logic [7:0] high_w_q;       // read strobe high width setting
  logic [7:0] ctrl_q;         // bus width select
  logic       valid_q;        // read result ready
  logic [7:0] input_low_byte_q;   // captured low lane
  logic [7:0] input_high_byte_q;  // captured high lane
  logic       cmd_read_q;     // latched command: read
  logic       cmd_dc_q;       // latched command: d/c value
  logic [7:0] lo_q;           // write low byte, wide mode

  // ************************************************************
  // queue
  // ************************************************************
  logic                     q_pop;     // engine takes a byte
  logic [7:0]               q_data;    // byte popped last
  logic                     q_empty;   // nothing queued
  logic                     q_full;    // no room at all
  logic [$clog2(DEPTH):0]   q_free;    // bytes of room

  // software pushes command and data bytes through one port, so
  // the bus sees them exactly in issue order
  wire q_push = req.wr & (req.addr == OFS_QUEUE);

  cmd_queue #(
    .WIDTH (8),
    .DEPTH (DEPTH)
  ) u_queue (
    .ref_clk    (ref_clk),
    .sys_rst    (sys_rst),
    .push       (q_push),
    .push_data  (req.wdata),
    .pop        (q_pop),
    .pop_data_q (q_data),
    .empty      (q_empty),
    .full       (q_full),
    .free       (q_free)
  );

  // the depth holds two 16-bit writes (three bytes each), so two
  // writes can be posted while the engine is busy
  wire room = (q_free >= ($clog2(DEPTH)+1)'(ROOM_MIN));

  // ************************************************************
  // strobe width timer
  // ************************************************************
  // widths below the floor are raised to it; 8 bits cap at 255
  wire [7:0] low_eff  = (low_w_q  < LOW_W_MIN)  ? LOW_W_MIN
                                                : low_w_q;
  wire [7:0] high_eff = (high_w_q < HIGH_W_MIN) ? HIGH_W_MIN
                                                : high_w_q;

  logic       t_load;   // start a phase
  logic [7:0] t_value;  // phase length
  logic [7:0] t_left;   // cycles left in phase, this one included

  strobe_timer #(
    .W (8)
  ) u_timer (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .load    (t_load),
    .value   (t_value),
    .left_q  (t_left)
  );

  // ************************************************************
  // engine decode
  // ************************************************************
  wire wide      = ctrl_q[CTRL_WIDE];
  wire cmd_rd    = q_data[CMD_READ];            // command decode
  wire last_phase = (t_left == 8'h01);          // final cycle
  // sample one edge before select and strobe rise
  wire sample    = (state_q == S_R_LOW) & (t_left == 8'h02);
  wire rd_done   = (state_q == S_R_HIGH) & last_phase;

  // next state; every transaction ends in S_IDLE, so the next one
  // starts only after an idle and a command cycle
  always_comb begin
    state_d = state_q;
    q_pop   = 1'b0;
    t_load  = 1'b0;
    t_value = low_eff;
    unique case (state_q)
      S_IDLE: begin
        if (!q_empty) begin
          q_pop   = 1'b1;
          state_d = S_CMD;
        end
      end
      S_CMD: begin
        if (cmd_rd) begin
          // a read leaves the queue alone; earlier writes are done
          t_load  = 1'b1;
          state_d = S_R_LOW;
        end else if (!q_empty) begin
          q_pop   = 1'b1;
          state_d = S_DATA_LO;
        end
      end
      S_DATA_LO: begin
        if (!wide) begin
          state_d = S_W_SETUP;
        end else if (!q_empty) begin
          q_pop   = 1'b1;
          state_d = S_DATA_HI;
        end
      end
      S_DATA_HI: begin
        state_d = S_W_SETUP;
      end
      // three fixed cycles, whatever the width
      S_W_SETUP: begin
        state_d = S_W_STB;
      end
      S_W_STB: begin
        state_d = S_W_HOLD;
      end
      S_W_HOLD: begin
        // the fetch of the next command keeps the strobe high for
        // hold, idle, command and data cycles before next setup
        state_d = S_IDLE;
      end
      S_R_LOW: begin
        if (last_phase) begin
          t_load  = 1'b1;
          t_value = high_eff;
          state_d = S_R_HIGH;
        end
      end
      S_R_HIGH: begin
        if (last_phase) begin
          state_d = S_IDLE;
        end
      end
      default: begin
        state_d = S_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_q <= S_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // command and write data latches follow the queue output
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cmd_read_q <= 1'b0;
      cmd_dc_q   <= 1'b0;
      lo_q       <= 8'h00;
    end else begin
      if (state_q == S_CMD) begin
        cmd_read_q <= q_data[CMD_READ];
        cmd_dc_q   <= q_data[CMD_DC];
      end
      if (state_q == S_DATA_LO) begin
        lo_q <= q_data;
      end
    end
  end

  // ************************************************************
  // pin drive, registered from the next state
  // ************************************************************
  wire nx_write  = (state_d == S_W_SETUP) | (state_d == S_W_STB)
                 | (state_d == S_W_HOLD);
  wire nx_sel    = nx_write | (state_d == S_R_LOW);
  // select is set a cycle before the write strobe falls, together with the read strobe
  wire load_dc   = (state_q == S_CMD);
  wire load_out  = (state_d == S_W_SETUP) & (state_q != S_W_SETUP);
  // the last data byte comes straight off the queue output: a latch
  // would only fill at the very edge that loads the pins
  wire [7:0] lo_lane = wide ? lo_q : q_data;
  // narrow mode leaves the high lane at zero
  wire [7:0] hi_lane = wide ? q_data : 8'h00;

  lcd_pins_t pins_d;  // next pin values
  // idle: selects and strobes high, enable low
  assign pins_d.cs_n    = ~nx_sel;
  assign pins_d.wr_n    = ~(state_d == S_W_STB);
  assign pins_d.rd_n    = ~(state_d == S_R_LOW);
  assign pins_d.oe      = nx_write;
  // d/c and data keep their last value outside transactions
  assign pins_d.dc      = load_dc ? q_data[CMD_DC]
                                  : pins_q.dc;
  assign pins_d.out_bus = load_out ? {hi_lane, lo_lane}
                                   : pins_q.out_bus;

  // pin register
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pins_q <= '{dc: 1'b0, cs_n: 1'b1, wr_n: 1'b1, rd_n: 1'b1,
                  oe: 1'b0, out_bus: 16'h0000};
    end else begin
      pins_q <= pins_d;
    end
  end

  // ************************************************************
  // register port decode
  // ************************************************************
  wire rd_flags = req.rd & (req.addr == OFS_FLAGS);
  wire rd_low   = req.rd & (req.addr == OFS_RD_LOW);
  wire rd_high  = req.rd & (req.addr == OFS_RD_HIGH);
  wire wr_low_w  = req.wr & (req.addr == OFS_LOW_W);
  wire wr_high_w = req.wr & (req.addr == OFS_HIGH_W);
  wire wr_ctrl   = req.wr & (req.addr == OFS_CTRL);
  wire busy      = (state_q != S_IDLE);

  // status byte; reserved bits read zero
  wire [7:0] flags = {5'b00000, busy, valid_q, room};

  // read mux; unmapped addresses read zero
  logic [7:0] rmux;
  always_comb begin
    unique case (req.addr)
      OFS_FLAGS:   rmux = flags;
      OFS_RD_LOW:  rmux = input_low_byte_q;
      OFS_RD_HIGH: rmux = input_high_byte_q;
      OFS_LOW_W:   rmux = low_w_q;
      OFS_HIGH_W:  rmux = high_w_q;
      OFS_CTRL:    rmux = ctrl_q;
      default:     rmux = 8'h00;
    endcase
  end

  // read data stand in the cycle after the strobe only
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= req.rd ? rmux : 8'h00;
    end
  end

  // configuration writes; a change mid-read affects next phase
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      low_w_q  <= LOW_W_RST;
      high_w_q <= HIGH_W_RST;
      ctrl_q   <= CTRL_RST;
    end else begin
      if (wr_low_w) begin
        low_w_q <= req.wdata;
      end
      if (wr_high_w) begin
        high_w_q <= req.wdata;
      end
      if (wr_ctrl) begin
        ctrl_q <= req.wdata;
      end
    end
  end

  // ************************************************************
  // read result
  // ************************************************************
  // capture beats a same-cycle clearing read, so no sample is lost
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      input_low_byte_q  <= 8'h00;
      input_high_byte_q <= 8'h00;
    end else begin
      if (sample) begin
        input_low_byte_q <= in_bus[7:0];
      end else if (rd_low) begin
        input_low_byte_q <= 8'h00;
      end
      if (sample) begin
        input_high_byte_q <= wide ? in_bus[15:8]
                                  : 8'h00;
      end else if (rd_high) begin
        input_high_byte_q <= 8'h00;
      end
    end
  end

  // valid rises when the read ends; software polls it, and a set
  // in the clearing cycle wins
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      valid_q <= 1'b0;
    end else if (rd_done) begin
      valid_q <= 1'b1;
    end else if (rd_flags) begin
      valid_q <= 1'b0;
    end
  end

endmodule : lcd_parallel_bus_master

// *** verif/lcd_parallel_bus_master_assertions.sv ***
// assertion checker for the lcd parallel bus master
`timescale 1ns/1ps
module lcd_bus_checker #(
  parameter int unsigned DEPTH = 8
) (
  // clock and reset
  input wire logic                   ref_clk,
  input wire logic                   sys_rst,
  // register port
  input wire lcd_bus_pkg::reg_req_t  req,
  input wire logic [7:0]             rdata_q,
  // panel pins
  input wire lcd_bus_pkg::lcd_pins_t pins_q,
  input wire logic [15:0]            in_bus
);
  import lcd_bus_pkg::*;
  // ************************************************************
  // one clock domain, reset disables every check
  // ************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  // ************************************************************
  // pin relations
  // ************************************************************
  idle_pins_a: assert property (
    pins_q.cs_n |-> pins_q.wr_n && pins_q.rd_n && !pins_q.oe)
    else $error("strobe or enable active while deselected");
  write_frame_a: assert property (
    $rose(pins_q.oe) |-> !pins_q.cs_n && pins_q.wr_n ##1 !pins_q.wr_n
    ##1 pins_q.wr_n && pins_q.oe ##1 !pins_q.oe && pins_q.cs_n)
    else $error("write frame not three cycles");
  write_gap_a: assert property (
    $rose(pins_q.wr_n) |-> pins_q.wr_n [*3])
    else $error("write strobe high too short");
  read_release_a: assert property (
    !pins_q.rd_n |-> !pins_q.oe && !pins_q.cs_n && pins_q.wr_n)
    else $error("bus driven or strobes mixed during read");
  read_low_a: assert property (
    $fell(pins_q.rd_n) |-> !pins_q.rd_n [*2])
    else $error("read strobe low under two cycles");
  select_hold_a: assert property (
    !pins_q.cs_n && !$past(pins_q.cs_n) |-> $stable(pins_q.dc))
    else $error("select moved inside a transfer");
  data_hold_a: assert property (
    pins_q.oe && $past(pins_q.oe) |-> $stable(pins_q.out_bus))
    else $error("write data moved while driven");
  rdata_quiet_a: assert property (
    !$past(req.rd) |-> rdata_q == 8'h00)
    else $error("read data outside its cycle");

  // main scenarios reached
  write_seen_c: cover property ($rose(pins_q.oe));
  read_seen_c:  cover property ($fell(pins_q.rd_n));
  data_seen_c:  cover property (rdata_q != 8'h00);
endmodule : lcd_bus_checker

bind lcd_parallel_bus_master lcd_bus_checker #(.DEPTH(DEPTH)) u_chk (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .req(req), .rdata_q(rdata_q),
  .pins_q(pins_q), .in_bus(in_bus));

// *** verif/lcd_panel_model.sv ***
// behavioural model of the external lcd controller chip
`timescale 1ns/1ps
module lcd_panel_model (
  // clock and reset
  input  wire logic                   ref_clk,
  input  wire logic                   sys_rst,
  // panel pins
  input  wire lcd_bus_pkg::lcd_pins_t pins_q,
  output logic [15:0]                 in_bus,
  // behaviour chosen by the bench
  input  wire logic [15:0]            rd_val,
  input  wire logic [7:0]             acc,
  // observed traffic
  output logic [7:0]                  wr_cnt,
  output logic                        wr_dc,
  output logic [15:0]                 wr_data,
  output logic [7:0]                  wr_at_rd,
  output logic [7:0]                  low_w
);
  import lcd_bus_pkg::*;
  logic [7:0]  cnt;                 // cycles of current read strobe
  logic [15:0] junk = 16'h0f0f;     // released bus keeps flipping
  // data only after the access delay, so an early sample catches junk
  assign in_bus = (!pins_q.cs_n && !pins_q.rd_n && cnt >= acc) ?
                  rd_val : junk;
  // log writes in the strobe cycle and time read strobes
  always @(posedge ref_clk) begin
    junk <= ~in_bus;
    if (sys_rst) begin
      wr_cnt <= 8'h00;
      cnt    <= 8'h00;
    end else begin
      if (!pins_q.cs_n && !pins_q.wr_n) begin
        wr_cnt  <= wr_cnt + 8'h01;
        wr_dc   <= pins_q.dc;
        // undriven lines read as the inverse
        wr_data <= pins_q.oe ? pins_q.out_bus : ~pins_q.out_bus;
      end
      if (!pins_q.rd_n) begin
        cnt <= cnt + 8'h01;
        if (cnt == 8'h00) begin
          wr_at_rd <= wr_cnt;
        end
      end else if (cnt != 8'h00) begin
        low_w <= cnt;
        cnt   <= 8'h00;
      end
    end
  end
endmodule : lcd_panel_model

// *** verif/lcd_parallel_bus_master_test.sv ***
// self-checking testbench for the lcd parallel bus master
`timescale 1ns/1ps
module lcd_parallel_bus_master_test;
  import lcd_bus_pkg::*;
  // ************************************************************
  // wiring
  // ************************************************************
  logic        ref_clk = 1'b0; // 100 MHz
  logic        sys_rst;        // synchronous reset
  reg_req_t    req;            // register request
  logic [7:0]  rdata_q;        // register read data
  lcd_pins_t   pins_q;         // panel pins
  logic [15:0] in_bus;         // panel data back
  logic [15:0] rd_val;         // value the panel returns
  logic [7:0]  acc;            // panel access delay
  logic [7:0]  wr_cnt;         // writes seen on the pins
  logic        wr_dc;          // select of last write
  logic [15:0] wr_data;        // data of last write
  logic [7:0]  wr_at_rd;       // writes done when a read began
  logic [7:0]  low_w;          // last read strobe low width
  int          failures = 0;
  int          compares = 0;
  int          cycles = 0;

  always #5 ref_clk = ~ref_clk;

  lcd_parallel_bus_master u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .req(req), .rdata_q(rdata_q), .pins_q(pins_q), .in_bus(in_bus));
  lcd_panel_model u_panel (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .pins_q(pins_q), .in_bus(in_bus), .rd_val(rd_val), .acc(acc),
    .wr_cnt(wr_cnt), .wr_dc(wr_dc), .wr_data(wr_data),
    .wr_at_rd(wr_at_rd), .low_w(low_w));

  // ************************************************************
  // bus tasks and comparison
  // ************************************************************
  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk

  task automatic reg_wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    req <= '{1'b1, 1'b0, a, d};
    @(posedge ref_clk);
    req <= '0;
  endtask : reg_wr

  // read data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [4:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge ref_clk);
    req <= '0;
    #1 d = rdata_q;
  endtask : reg_rd

  task automatic rd_chk(input string what, input logic [4:0] a,
                        input logic [7:0] exp);
    logic [7:0] d;
    reg_rd(a, d);
    chk(what, {8'h00, exp}, {8'h00, d});
  endtask : rd_chk

  // bytes into the queue with back-to-back strobes
  task automatic push(input logic [7:0] b[$]);
    foreach (b[i]) begin
      @(posedge ref_clk);
      req <= '{1'b1, 1'b0, OFS_QUEUE, b[i]};
    end
    @(posedge ref_clk);
    req <= '0;
  endtask : push

  task automatic wait_wr(input logic [7:0] n);
    for (int i = 0; i < 60 && wr_cnt !== n; i++) @(posedge ref_clk);
    chk("write count", {8'h00, n}, {8'h00, wr_cnt});
  endtask : wait_wr

  // software polls the flags before touching read data
  task automatic wait_valid;
    logic [7:0] f;
    f = 8'h00;
    for (int i = 0; i < 100 && f[FLG_VALID] !== 1'b1; i++) begin
      reg_rd(OFS_FLAGS, f);
    end
    chk("valid flag", 16'h0001, {15'h0000, f[FLG_VALID]});
  endtask : wait_valid

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_reset;
    chk("idle pins", 16'h000e, {12'h000, pins_q.cs_n, pins_q.wr_n,
        pins_q.rd_n, pins_q.oe});
    rd_chk("flags", OFS_FLAGS, 8'h01);
    rd_chk("low data", OFS_RD_LOW, 8'h00);
    rd_chk("high data", OFS_RD_HIGH, 8'h00);
    rd_chk("low width", OFS_LOW_W, LOW_W_RST);
    rd_chk("high width", OFS_HIGH_W, HIGH_W_RST);
    rd_chk("unmapped", 5'h1c, 8'h00);
    $display("reset test done");
  endtask : t_reset

  // both select values, 8-bit lane only
  task automatic t_write8;
    for (int k = 0; k < 2; k++) begin
      push('{{6'h00, k[0], 1'b0}, 8'h5a + k[7:0]});
      wait_wr(k[7:0] + 8'h01);
      chk("select", {15'h0000, k[0]}, {15'h0000, wr_dc});
      chk("write data", {8'h00, 8'h5a + k[7:0]}, wr_data);
    end
    rd_chk("flags idle", OFS_FLAGS, 8'h01);
    $display("write test done");
  endtask : t_write8

  // two posted 16-bit writes then a read, all queued at once
  task automatic t_order;
    reg_wr(OFS_CTRL, 8'h01);
    reg_wr(OFS_LOW_W, 8'h04);
    reg_wr(OFS_HIGH_W, 8'h03);
    rd_val <= 16'hc35a;
    acc    <= 8'h02;
    push('{8'h02, 8'h34, 8'h12, 8'h00, 8'hcd, 8'hab, 8'h03});
    wait_valid();
    chk("writes before read", 16'h0004, {8'h00, wr_at_rd});
    chk("second write", 16'habcd, wr_data);
    chk("second select", 16'h0000, {15'h0000, wr_dc});
    chk("strobe low", 16'h0004, {8'h00, low_w});
    rd_chk("flags cleared", OFS_FLAGS, 8'h01);
    rd_chk("low byte", OFS_RD_LOW, 8'h5a);
    rd_chk("high byte", OFS_RD_HIGH, 8'hc3);
    rd_chk("low cleared", OFS_RD_LOW, 8'h00);
    rd_chk("high cleared", OFS_RD_HIGH, 8'h00);
    $display("order test done");
  endtask : t_order

  // widths below the floor fall back to the shortest strobe
  task automatic t_rdmin;
    reg_wr(OFS_CTRL, 8'h00);
    reg_wr(OFS_LOW_W, 8'h00);
    reg_wr(OFS_HIGH_W, 8'h00);
    rd_val <= 16'h7e81;
    acc    <= 8'h00;
    push('{8'h01});
    rd_chk("flags busy", OFS_FLAGS, 8'h05);
    wait_valid();
    chk("strobe low min", 16'h0002, {8'h00, low_w});
    rd_chk("low byte", OFS_RD_LOW, 8'h81);
    rd_chk("high byte", OFS_RD_HIGH, 8'h00);
    $display("short read test done");
  endtask : t_rdmin

  // ************************************************************
  // verdict and hang guard
  // ************************************************************
  task automatic end_sim;
    $display("compares %0d, failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_sim

  // the run needs a few thousand cycles at most
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      end_sim();
    end
  end

  initial begin
    sys_rst = 1'b1;
    req     = '0;
    rd_val  = 16'h0000;
    acc     = 8'h00;
    repeat (5) @(posedge ref_clk);
    sys_rst <= 1'b0;
    t_reset();
    t_write8();
    t_order();
    t_rdmin();
    end_sim();
  end
endmodule : lcd_parallel_bus_master_test
